/* bst_test_port.sv */
// bst_test_port.sv: test access port with instruction, bypass, id and boundary paths
// assumes tck, tms, tdi and trst_n come from pins; clk_sys is much faster than tck
`timescale 1ns/1ns
`default_nettype none
`include "bst_map.svh"

module bst_test_port #(
  parameter int CELLS = 8,
  parameter logic [3:0] REV_CODE = 4'h1,   // arbitrary
  parameter logic [15:0] PART_CODE = 16'h1234, // arbitrary
  parameter logic [10:0] MFR_CODE = 11'h155  // arbitrary
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [CELLS-1:0] func_in,
  input wire logic [CELLS-1:0] core_out,
  input wire logic [CELLS-1:0] core_oe,
  output logic [CELLS-1:0] pin_out,
  output logic [CELLS-1:0] pin_oe,
  output var bst_pkg::bst_instr_t instr_q
);
  import bst_pkg::*;

  localparam logic [`BST_ID_W-1:0] ID_WORD = {REV_CODE, PART_CODE, MFR_CODE, `BST_ID_MARK};
  localparam int HALF = CELLS / 2;

  // the capture split needs two equal halves, so odd or tiny counts stop elaboration
  if (CELLS < 2 || (CELLS % 2) != 0) begin : gen_bad_cells
    $error("bst_test_port needs an even cell count of two or more");
  end

  // pin synchronisers: stage one feeds only stage two
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic tck_prev_r;
  logic trst_hold_r;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      tck_prev_r <= 1'b0;
    end else begin
      sync1_r <= {trst_n, tdi, tms, tck};
      sync2_r <= sync1_r;
      tck_prev_r <= sync2_r[0];
    end
  end

  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_s_n;
  logic rise;
  logic fall;
  assign tck_s = sync2_r[0];
  assign tms_s = sync2_r[1];
  assign tdi_s = sync2_r[2];
  assign trst_s_n = sync2_r[3];
  // tck at 10 MHz gives several clk_sys samples per phase
  assign rise = tck_s & ~tck_prev_r;
  assign fall = ~tck_s & tck_prev_r;

  // controller state and shift registers
  bst_state_t state_r;
  bst_state_t state_nxt;
  bst_instr_t ir_sh_r;
  bst_instr_t ir_sh_nxt;
  bst_instr_t ir_r;
  bst_instr_t ir_nxt;
  logic byp_r;
  logic byp_nxt;
  logic [`BST_ID_W-1:0] id_sh_r;
  logic [`BST_ID_W-1:0] id_sh_nxt;
  logic tdo_r;
  logic tdo_nxt;
  logic oe_r;
  logic oe_nxt;
  logic [CELLS-1:0] pout_r;
  logic [CELLS-1:0] pout_nxt;
  logic [CELLS-1:0] poe_r;
  logic [CELLS-1:0] poe_nxt;

  logic sel_bsr;
  logic sel_id;
  logic drive_cells;
  logic cap_en;
  logic sh_en;
  logic upd_en;
  logic chain_so;
  logic [CELLS-1:0] cap_vec;
  logic [CELLS-1:0] cells_q;

  // data register selection; reserved codes fall back to bypass
  always_comb begin
    sel_bsr = (ir_r == `BST_IR_EXTEST) || (ir_r == `BST_IR_SAMPLE);
    sel_id = (ir_r == `BST_IR_IDCODE);
    drive_cells = (ir_r == `BST_IR_EXTEST) || (ir_r == `BST_IR_CLAMP);
  end

  assign cap_en = rise && state_r == BST_CAP_DR && sel_bsr;
  assign sh_en = rise && state_r == BST_SH_DR && sel_bsr;
  assign upd_en = fall && state_r == BST_UPD_DR && sel_bsr;
  // lower half of the cells watch input pins, upper half the core's output values
  assign cap_vec = {core_out[CELLS-1:HALF], func_in[HALF-1:0]};

  bst_cell_chain #(
    .CELLS(CELLS)
  ) u_chain (
    .clk_sys(clk_sys),
    .rst(rst),
    .capture_en(cap_en),
    .shift_en(sh_en),
    .update_en(upd_en),
    .serial_in(tdi_s),
    .parallel_in(cap_vec),
    .serial_out(chain_so),
    .update_q(cells_q)
  );

  // tap next state, register capture/shift on tck rise, update and tdo on tck fall
  always_comb begin
    state_nxt = state_r;
    ir_sh_nxt = ir_sh_r;
    ir_nxt = ir_r;
    byp_nxt = byp_r;
    id_sh_nxt = id_sh_r;
    tdo_nxt = tdo_r;
    oe_nxt = oe_r;
    if (rise) begin
      unique case (state_r)
        BST_RESET: state_nxt = tms_s ? BST_RESET : BST_IDLE;
        BST_IDLE: state_nxt = tms_s ? BST_SEL_DR : BST_IDLE;
        BST_SEL_DR: state_nxt = tms_s ? BST_SEL_IR : BST_CAP_DR;
        BST_CAP_DR: state_nxt = tms_s ? BST_EX1_DR : BST_SH_DR;
        BST_SH_DR: state_nxt = tms_s ? BST_EX1_DR : BST_SH_DR;
        BST_EX1_DR: state_nxt = tms_s ? BST_UPD_DR : BST_PAUSE_DR;
        BST_PAUSE_DR: state_nxt = tms_s ? BST_EX2_DR : BST_PAUSE_DR;
        BST_EX2_DR: state_nxt = tms_s ? BST_UPD_DR : BST_SH_DR;
        BST_UPD_DR: state_nxt = tms_s ? BST_SEL_DR : BST_IDLE;
        BST_SEL_IR: state_nxt = tms_s ? BST_RESET : BST_CAP_IR;
        BST_CAP_IR: state_nxt = tms_s ? BST_EX1_IR : BST_SH_IR;
        BST_SH_IR: state_nxt = tms_s ? BST_EX1_IR : BST_SH_IR;
        BST_EX1_IR: state_nxt = tms_s ? BST_UPD_IR : BST_PAUSE_IR;
        BST_PAUSE_IR: state_nxt = tms_s ? BST_EX2_IR : BST_PAUSE_IR;
        BST_EX2_IR: state_nxt = tms_s ? BST_UPD_IR : BST_SH_IR;
        BST_UPD_IR: state_nxt = tms_s ? BST_SEL_DR : BST_IDLE;
      endcase
      unique case (state_r)
        BST_CAP_IR: ir_sh_nxt = `BST_IR_CAPTURE;
        BST_SH_IR: ir_sh_nxt = {tdi_s, ir_sh_r[`BST_IR_W-1:1]};
        BST_CAP_DR: begin
          byp_nxt = 1'b0;
          id_sh_nxt = ID_WORD;
        end
        BST_SH_DR: begin
          byp_nxt = tdi_s;
          id_sh_nxt = {tdi_s, id_sh_r[`BST_ID_W-1:1]};
        end
        default: begin
        end
      endcase
    end
    if (fall) begin
      if (state_r == BST_UPD_IR) begin
        ir_nxt = ir_sh_r;
      end
      oe_nxt = (state_r == BST_SH_IR) || (state_r == BST_SH_DR);
      if (state_r == BST_SH_IR) begin
        tdo_nxt = ir_sh_r[0];
      end else if (state_r == BST_SH_DR) begin
        tdo_nxt = sel_bsr ? chain_so : (sel_id ? id_sh_r[0] : byp_r);
      end
      if (state_r == BST_RESET) begin
        ir_nxt = `BST_IR_RESET; // id code is the reset instruction
      end
    end
    // test reset wins over the tck updates of state, instruction and tdo enable
    if (!trst_s_n) begin
      state_nxt = BST_RESET;
      ir_nxt = `BST_IR_RESET;
      oe_nxt = 1'b0;
    end
  end

  // pin muxing: boundary cells, float, or core path
  always_comb begin
    if (ir_r == `BST_IR_HIGHZ) begin
      pout_nxt = core_out;
      poe_nxt = '0;
    end else if (drive_cells) begin
      pout_nxt = cells_q;
      poe_nxt = {CELLS{1'b1}};
    end else begin
      pout_nxt = core_out;
      poe_nxt = core_oe;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_r <= BST_RESET;
      ir_sh_r <= `BST_IR_RESET;
      ir_r <= `BST_IR_RESET;
      byp_r <= 1'b0;
      id_sh_r <= '0;
      tdo_r <= 1'b0;
      oe_r <= 1'b0;
      pout_r <= '0;
      poe_r <= '0;
    end else begin
      state_r <= state_nxt;
      ir_sh_r <= ir_sh_nxt;
      ir_r <= ir_nxt;
      byp_r <= byp_nxt;
      id_sh_r <= id_sh_nxt;
      tdo_r <= tdo_nxt;
      oe_r <= oe_nxt;
      pout_r <= pout_nxt;
      poe_r <= poe_nxt;
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe = oe_r;
  assign pin_out = pout_r;
  assign pin_oe = poe_r;
  assign instr_q = ir_r;
endmodule

`default_nettype wire

/* bst_map.svh */
// bst_map.svh: named constants for the boundary scan test port
// assumes inclusion by bare name from the package and the test port module
`ifndef BST_MAP_SVH
`define BST_MAP_SVH

`define BST_IR_W 4
`define BST_ID_W 32
`define BST_IR_EXTEST 4'h0
`define BST_IR_SAMPLE 4'h1
`define BST_IR_IDCODE 4'h2
`define BST_IR_CLAMP 4'h3
`define BST_IR_HIGHZ 4'h4
`define BST_IR_BYPASS 4'hf
`define BST_IR_CAPTURE 4'h1
`define BST_IR_RESET 4'h2
`define BST_ID_REV_HI 31
`define BST_ID_REV_LO 28
`define BST_ID_PART_HI 27
`define BST_ID_PART_LO 12
`define BST_ID_MFR_HI 11
`define BST_ID_MFR_LO 1
`define BST_ID_MARK 1'b1
`define BST_TEST_CLK_MHZ 10

`endif

/* bst_pkg.sv */
// bst_pkg.sv: types shared by the boundary scan test port modules
// assumes bst_map.svh is on the include path
`include "bst_map.svh"

package bst_pkg;
  typedef enum logic [3:0] {
    BST_RESET, BST_IDLE, BST_SEL_DR, BST_CAP_DR, BST_SH_DR, BST_EX1_DR, BST_PAUSE_DR, BST_EX2_DR,
    BST_UPD_DR, BST_SEL_IR, BST_CAP_IR, BST_SH_IR, BST_EX1_IR, BST_PAUSE_IR, BST_EX2_IR, BST_UPD_IR
  } bst_state_t;
  typedef logic [`BST_IR_W-1:0] bst_instr_t;
endpackage

/* bst_cell_chain.sv */
// bst_cell_chain.sv: boundary cell chain with capture, shift and update stages
// assumes single-cycle enables from the port controller on the same clock
`timescale 1ns/1ns
`default_nettype none

module bst_cell_chain #(
  parameter int CELLS = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic capture_en,
  input wire logic shift_en,
  input wire logic update_en,
  input wire logic serial_in,
  input wire logic [CELLS-1:0] parallel_in,
  output logic serial_out,
  output logic [CELLS-1:0] update_q
);
  import bst_pkg::*;

  logic [CELLS-1:0] shift_r;
  logic [CELLS-1:0] shift_nxt;
  logic [CELLS-1:0] upd_r;
  logic [CELLS-1:0] upd_nxt;

  // refuse an empty chain while elaborating, before any logic is built
  if (CELLS < 1) begin : gen_bad_cells
    $error("bst_cell_chain needs at least one cell");
  end

  // one stage per cell; cell 0 sits next to the serial output
  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : gen_cell
      logic from_up;
      if (g == CELLS - 1) begin : gen_top
        assign from_up = serial_in; // preload enters here
      end else begin : gen_mid
        assign from_up = shift_r[g+1];
      end
      always_comb begin
        shift_nxt[g] = shift_r[g];
        if (capture_en) begin
          shift_nxt[g] = parallel_in[g]; // sample pins
        end else if (shift_en) begin
          shift_nxt[g] = from_up;
        end
        upd_nxt[g] = update_en ? shift_r[g] : upd_r[g];
      end
    end
  endgenerate

  // update stage only changes on update so outputs never ripple during shift
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_r <= '0;
      upd_r <= '0;
    end else begin
      shift_r <= shift_nxt;
      upd_r <= upd_nxt;
    end
  end

  assign serial_out = shift_r[0];
  assign update_q = upd_r;
endmodule

`default_nettype wire

/* bst_ctrl_model.sv */
// bst_ctrl_model.sv: behavioural scan controller on the test pins
// assumes clk_sys of 40 ns; tck is 8 of those and rests low between frames
`timescale 1ns/1ns
`default_nettype none
module bst_ctrl_model (
  input wire logic clk_sys,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b1;
  end
  // one tck cycle of 8 clk_sys at one fixed rate; tms and tdi move only while tck is low
  task automatic tick(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    repeat (4) @(negedge clk_sys);
    q = tdo_oe ? tdo : 1'b1; // a released tdo line reads as its pull-up
    tck = 1'b1;
    repeat (4) @(negedge clk_sys);
    tck = 1'b0;
  endtask
  // idle, capture, shift lsb first, update, idle; only defined codes are sent
  task automatic scan(input logic ir, input logic [31:0] din, input int n, output logic [31:0] dout);
    logic q;
    dout = '0;
    tick(1'b1, 1'b0, q);
    if (ir) tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
    tick(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    tick(1'b1, 1'b0, q);
    tick(1'b0, 1'b0, q);
  endtask
  // held well past the two-flop sync
  task automatic trst_pulse;
    trst_n = 1'b0;
    repeat (8) @(negedge clk_sys);
    trst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule
`default_nettype wire

/* bst_test_port_props.sv */
// bst_test_port_props.sv: port checks for the test port
// assumes bst_pkg is compiled first; bound into every bst_test_port
`timescale 1ns/1ns
`default_nettype none
module bst_test_port_chk #(
  parameter int CELLS = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic [CELLS-1:0] func_in,
  input wire logic [CELLS-1:0] core_out,
  input wire logic [CELLS-1:0] core_oe,
  input wire logic [CELLS-1:0] pin_out,
  input wire logic [CELLS-1:0] pin_oe,
  input wire bst_pkg::bst_instr_t instr_q
);
  import bst_pkg::*;
  // one domain, so clock and reset are named once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // $past(rst) keeps the first edge after release out of the pass-through checks
  sequence core_path;
    !$past(rst) && $stable(instr_q) && !(instr_q inside {4'h0, 4'h3, 4'h4});
  endsequence
  a_trst_instr: assert property (!trst_n [*5] |=> instr_q == 4'h2)
    else $error("test reset left instruction");
  a_trst_quiet: assert property (!trst_n [*5] |=> !tdo_oe)
    else $error("test reset left tdo driven");
  // a move shows one clk after it lands, so look back over the low phase that launched it
  a_tdo_low: assert property ($changed(tdo) |-> !$past(tck) && !$past(tck, 2))
    else $error("tdo moved with tck high");
  // test reset may strike in any tck phase, so its forced changes are left out
  a_instr_low: assert property ($changed(instr_q) && $past(trst_n, 3) |-> !$past(tck) && !$past(tck, 2))
    else $error("instruction moved with tck high");
  a_oe_low: assert property ($changed(tdo_oe) && $past(trst_n, 3) |-> !$past(tck) && !$past(tck, 2))
    else $error("tdo enable moved with tck high");
  a_highz_float: assert property ($stable(instr_q) && instr_q == 4'h4 |-> pin_oe == '0)
    else $error("pins driven under float");
  // pins settle one clk after the code lands, so hold only from the third clamp cycle on
  a_clamp_hold: assert property (instr_q == 4'h3 && $past(instr_q) == 4'h3 && $past(instr_q, 2) == 4'h3
    |-> $stable(pin_out))
    else $error("pins moved under clamp");
  a_core_out: assert property (core_path |-> pin_out == $past(core_out))
    else $error("pins not following core");
  a_core_oe: assert property (core_path |-> pin_oe == $past(core_oe))
    else $error("enables not following core");
  c_float: cover property (instr_q == 4'h4);
  c_drive: cover property (instr_q == 4'h0);
  c_shift: cover property ($rose(tdo_oe));
endmodule
bind bst_test_port bst_test_port_chk #(.CELLS(CELLS)) i_chk (.clk_sys(clk_sys), .rst(rst), .tck(tck), .tms(tms),
  .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .func_in(func_in), .core_out(core_out),
  .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe), .instr_q(instr_q));
`default_nettype wire

/* tb_boundary_scan_test_port.sv */
// tb_boundary_scan_test_port.sv: self-checking bench for the test port
// assumes the controller model and checker are compiled before it
`timescale 1ns/1ns
`default_nettype none
module tb_boundary_scan_test_port;
  import bst_pkg::*;
  localparam logic [3:0] REV = 4'h5; // arbitrary
  localparam logic [15:0] PART = 16'hab12; // arbitrary
  localparam logic [10:0] MFR = 11'h2c3; // arbitrary
  logic clk_sys, rst, tck, tms, tdi, trst_n, tdo, tdo_oe, q;
  logic [7:0] func_in, core_out, core_oe, pin_out, pin_oe;
  logic [31:0] got;
  bst_instr_t instr_q;
  bst_instr_t codes [3] = '{4'h3, 4'h4, 4'hf};
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  bst_test_port #(.CELLS(8), .REV_CODE(REV), .PART_CODE(PART), .MFR_CODE(MFR)) i_dut (.clk_sys(clk_sys),
    .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe), .func_in(func_in),
    .core_out(core_out), .core_oe(core_oe), .pin_out(pin_out), .pin_oe(pin_oe), .instr_q(instr_q));
  bst_ctrl_model i_ctrl (.clk_sys(clk_sys), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // run needs about 1100 cycles, so this only trips on a hang
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic load(input bst_instr_t c);
    i_ctrl.scan(1'b1, {28'h0, c}, 4, got);
    cmp("ir capture", 32'h1, got);
    cmp("instruction", {28'h0, c}, {28'h0, instr_q});
  endtask
  task automatic test_done;
    if (err_total == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // halves of func_in and core_out differ so the capture split shows
  initial begin
    rst = 1'b1;
    func_in = 8'h66;
    core_out = 8'h99;
    core_oe = 8'hf0;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    i_ctrl.tick(1'b0, 1'b0, q);
    cmp("reset instruction", 32'h2, {28'h0, instr_q});
    i_ctrl.scan(1'b0, 32'h0, 32, got);
    cmp("id word", {REV, PART, MFR, 1'b1}, got);
    load(4'h1);
    i_ctrl.scan(1'b0, 32'h3c, 8, got);
    cmp("sampled cells", 32'h96, got);
    cmp("sample pins", 32'h99, {24'h0, pin_out});
    load(4'h0);
    cmp("preloaded pins", 32'h3c, {24'h0, pin_out});
    i_ctrl.scan(1'b0, 32'hc3, 8, got);
    cmp("extest chain", 32'h96, got);
    cmp("driven pins", 32'hc3, {24'h0, pin_out});
    foreach (codes[k]) begin
      load(codes[k]);
      i_ctrl.scan(1'b0, 32'h1, 2, got);
      cmp("bypass path", 32'h2, got);
      if (codes[k] == 4'h4) cmp("float enables", 32'h0, {24'h0, pin_oe});
      if (codes[k] == 4'h3) cmp("clamped pins", 32'hc3, {24'h0, pin_out});
    end
    cmp("bypass enables", 32'hf0, {24'h0, pin_oe});
    i_ctrl.trst_pulse();
    cmp("test reset instruction", 32'h2, {28'h0, instr_q});
    test_done();
  end
endmodule
`default_nettype wire
